// ==== mdmgt_defs.svh ====
// Offsets, field positions, reset values and timing counts of the management master
`ifndef MDMGT_DEFS_SVH
`define MDMGT_DEFS_SVH

// Control register byte offset inside the control/status block
`define MDMGT_CTRL_OFFSET 8'h10

// Field positions of the control register
`define MDMGT_IE_BIT 29
`define MDMGT_READY_BIT 28
`define MDMGT_OP_HI 27
`define MDMGT_OP_LO 26
`define MDMGT_SEL_HI 25
`define MDMGT_SEL_LO 21
`define MDMGT_IDX_HI 20
`define MDMGT_IDX_LO 16
`define MDMGT_DATA_HI 15
`define MDMGT_DATA_LO 0

// Operation codes
`define MDMGT_OP_WRITE 2'h1
`define MDMGT_OP_READ 2'h2

// Frame patterns
`define MDMGT_PREAMBLE 32'hffffffff
`define MDMGT_START 2'h1
`define MDMGT_TURN 2'h2

// Bit positions in the 64-bit frame
`define MDMGT_FRAME_LAST 6'h3f
`define MDMGT_READ_RELEASE 6'h2e
`define MDMGT_READ_FIRST_DATA 6'h30
`define MDMGT_PREAMBLE_BITS 6'h20

// Reset value of the ready flag: set, so the first command may go at once
`define MDMGT_READY_RESET 1'b1

// Timing: system clock and the fastest management clock, both in kHz
`define MDMGT_CLK_KHZ 125000
`define MDMGT_MDC_MAX_KHZ 2500
// Half period of the management clock in system cycles, rounded up
`define MDMGT_HALF_CYCLES \
   ((`MDMGT_CLK_KHZ + 2 * `MDMGT_MDC_MAX_KHZ - 1) / (2 * `MDMGT_MDC_MAX_KHZ))

`endif

// ==== mdmgt_pkg.sv ====
// Types shared by the management master files
package mdmgt_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      MDMGT_IDLE = 2'b00,
      MDMGT_RUN = 2'b01,
      MDMGT_SIGNAL = 2'b10,
      MDMGT_FINISH = 2'b11
   } mdmgt_state_type;

endpackage : mdmgt_pkg

// ==== mdmgt_clkdiv.sv ====
// Management clock divider with edge ticks
`timescale 1ns/1ns
module mdmgt_clkdiv #(
   parameter int HALF_CYCLES = 25
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   output logic mdc,
   output logic rise_tick,
   output logic fall_tick
);

   localparam int CW = $clog2(HALF_CYCLES + 1);
   localparam logic [CW-1:0] TERM = CW'(HALF_CYCLES - 1);

   logic [CW-1:0] cnt; // Cycles spent in current half period
   logic [CW-1:0] next_cnt;
   logic next_mdc;
   logic at_term;

   // Ticks fire in the cycle before the clock pin changes
   assign at_term = run && (cnt == TERM);
   assign rise_tick = at_term && !mdc;
   assign fall_tick = at_term && mdc;

   // Next count and clock level; stopped clock rests low
   always_comb begin
      next_cnt = cnt;
      next_mdc = mdc;
      if (!run) begin
         next_cnt = '0;
         next_mdc = 1'b0;
      end else if (at_term) begin
         next_cnt = '0;
         next_mdc = !mdc;
      end else begin
         next_cnt = cnt + CW'(1);
      end
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= '0;
         mdc <= 1'b0;
      end else begin
         cnt <= next_cnt;
         mdc <= next_mdc;
      end
   end

endmodule : mdmgt_clkdiv

// ==== mdmgt_master.sv ====
// Register-driven management serial master with its control register
`timescale 1ns/1ns
`include "mdmgt_defs.svh"
module mdmgt_master
   import mdmgt_pkg::*;
#(
   parameter int HALF_CYCLES = `MDMGT_HALF_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [3:0] reg_be,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic mgmt_irq,
   output logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe
);

   // Control register fields and their next values
   logic ie, next_ie; // Interrupt enable
   logic ready, next_ready; // Transfer finished flag
   logic [1:0] op, next_op; // Operation code
   logic [4:0] sel, next_sel; // Transceiver select
   logic [4:0] idx, next_idx; // Register index
   logic [15:0] data, next_data; // Data word, shifted in on reads
   logic [23:0] stage, next_stage; // Low bytes held until the top byte
   mdmgt_state_type state, next_state; // Sequencer state
   logic [63:0] frame, next_frame; // Outgoing bits, the one now on the line on top
   logic [5:0] bitno, next_bitno; // Bit currently on the line
   logic next_irq, next_mdio_out, next_mdio_oe; // Next pin levels
   logic [31:0] next_rdata; // Next read data
   logic mdio_meta; // First synchroniser stage, read only by the second stage
   logic mdio_sync; // Second synchroniser stage
   logic hit; // Access aimed at the control register
   logic take_cmd; // Command accepted this cycle
   logic [31:0] cmd; // Merged command word
   logic fall_tick; // Clock pin falls at the next edge
   logic run; // Frame in progress, divider running

   // Merge written lanes over the staged lanes
   function automatic logic [23:0] mdmgt_merge(input logic [2:0] be,
         input logic [23:0] old, input logic [23:0] wd);
      logic [23:0] m;
      m = old;
      for (int i = 0; i < 3; i++) begin
         if (be[i]) begin
            m[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return m;
   endfunction : mdmgt_merge

   assign hit = (reg_addr == `MDMGT_CTRL_OFFSET);
   // Only the top byte launches; writes while busy are dropped
   assign take_cmd = hit && reg_wr && reg_be[3] && (state == MDMGT_IDLE);
   assign cmd = {reg_wdata[31:24], mdmgt_merge(reg_be[2:0], stage,
         reg_wdata[23:0])};
   assign run = (state == MDMGT_RUN);

   // Clock divider keeps the pin at or below the rated rate
   mdmgt_clkdiv #(
      .HALF_CYCLES(HALF_CYCLES)
   ) i_mdmgt_clkdiv (
      .clk(clk),
      .rst_n(rst_n),
      .run(run),
      .mdc(mdc),
      .rise_tick(),
      .fall_tick(fall_tick)
   );

   // Pin input synchroniser; only the second stage is used
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mdio_meta <= 1'b1;
         mdio_sync <= 1'b1;
      end else begin
         mdio_meta <= mdio_in;
         mdio_sync <= mdio_meta;
      end
   end

   // Sequencer and register next values
   always_comb begin
      next_ie = ie;
      next_ready = ready;
      next_op = op;
      next_sel = sel;
      next_idx = idx;
      next_data = data;
      next_stage = stage;
      next_state = state;
      next_frame = frame;
      next_bitno = bitno;
      next_irq = mgmt_irq;
      next_mdio_out = mdio_out;
      next_mdio_oe = mdio_oe;
      // Low lanes are staged whenever written while idle
      if (hit && reg_wr && (state == MDMGT_IDLE)) begin
         next_stage = mdmgt_merge(reg_be[2:0], stage, reg_wdata[23:0]);
      end
      unique case (state)
         MDMGT_IDLE: begin
            if (take_cmd) begin
               next_ie = cmd[`MDMGT_IE_BIT];
               next_ready = cmd[`MDMGT_READY_BIT];
               next_op = cmd[`MDMGT_OP_HI:`MDMGT_OP_LO];
               next_sel = cmd[`MDMGT_SEL_HI:`MDMGT_SEL_LO];
               next_idx = cmd[`MDMGT_IDX_HI:`MDMGT_IDX_LO];
               next_data = cmd[`MDMGT_DATA_HI:`MDMGT_DATA_LO];
               next_irq = 1'b0;
               next_bitno = '0;
               // Read frames carry the written data field too, but the line is released from the first turnaround bit on
               next_frame = {`MDMGT_PREAMBLE, `MDMGT_START,
                     cmd[`MDMGT_OP_HI:`MDMGT_OP_LO],
                     cmd[`MDMGT_SEL_HI:`MDMGT_SEL_LO],
                     cmd[`MDMGT_IDX_HI:`MDMGT_IDX_LO], `MDMGT_TURN,
                     cmd[`MDMGT_DATA_HI:`MDMGT_DATA_LO]};
               if (cmd[`MDMGT_OP_HI:`MDMGT_OP_LO] == `MDMGT_OP_WRITE ||
                     cmd[`MDMGT_OP_HI:`MDMGT_OP_LO] == `MDMGT_OP_READ) begin
                  // First bit goes out with the clock low
                  next_state = MDMGT_RUN;
                  next_mdio_out = 1'b1;
                  next_mdio_oe = 1'b1;
               end else begin
                  // Reserved codes send nothing but still complete
                  next_state = MDMGT_SIGNAL;
               end
            end
         end
         MDMGT_RUN: begin
            if (fall_tick) begin
               // Read bits are taken at the end of each bit time
               if (op == `MDMGT_OP_READ &&
                     bitno >= `MDMGT_READ_FIRST_DATA) begin
                  next_data = {data[14:0], mdio_sync};
               end
               if (bitno == `MDMGT_FRAME_LAST) begin
                  next_state = MDMGT_SIGNAL;
                  next_mdio_oe = 1'b0; // Idle: line left to pull-up
                  next_mdio_out = 1'b1;
               end else begin
                  // New bit appears at the falling edge, sampled at rise
                  next_bitno = bitno + 6'h1;
                  next_frame = {frame[62:0], 1'b1};
                  next_mdio_out = frame[62];
                  next_mdio_oe = (op == `MDMGT_OP_WRITE) ||
                        (bitno + 6'h1 < `MDMGT_READ_RELEASE);
               end
            end
         end
         MDMGT_SIGNAL: begin
            next_irq = ie;
            next_state = MDMGT_FINISH;
         end
         MDMGT_FINISH: begin
            next_ready = 1'b1;
            next_state = MDMGT_IDLE;
         end
      endcase
   end

   // Read data path, one cycle after the address
   always_comb begin
      next_rdata = '0;
      if (hit) begin
         next_rdata = {2'b00, ie, ready, op, sel, idx, data};
      end
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ie <= 1'b0;
         ready <= `MDMGT_READY_RESET;
         op <= '0;
         sel <= '0;
         idx <= '0;
         data <= '0;
         stage <= '0;
         state <= MDMGT_IDLE;
         frame <= '0;
         bitno <= '0;
         mgmt_irq <= 1'b0;
         mdio_out <= 1'b1;
         mdio_oe <= 1'b0;
         reg_rdata <= '0;
      end else begin
         ie <= next_ie;
         ready <= next_ready;
         op <= next_op;
         sel <= next_sel;
         idx <= next_idx;
         data <= next_data;
         stage <= next_stage;
         state <= next_state;
         frame <= next_frame;
         bitno <= next_bitno;
         mgmt_irq <= next_irq;
         mdio_out <= next_mdio_out;
         mdio_oe <= next_mdio_oe;
         reg_rdata <= next_rdata;
      end
   end

   // Checks beside the logic
   property p_reserved_zero;
      @(posedge clk) disable iff (!rst_n) reg_rdata[31:30] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read non-zero");
   property p_cmd_launch;
      @(posedge clk) disable iff (!rst_n)
         take_cmd && (cmd[27:26] == `MDMGT_OP_WRITE) |=>
         (state == MDMGT_RUN) && mdio_oe && mdio_out;
   endproperty
   a_cmd_launch: assert property (p_cmd_launch)
      else $error("write command did not start a frame");
   property p_irq_before_ready;
      @(posedge clk) disable iff (!rst_n)
         (state == MDMGT_SIGNAL) && ie |=> mgmt_irq && !ready ##1 ready;
   endproperty
   a_irq_before_ready: assert property (p_irq_before_ready)
      else $error("interrupt and ready out of order");
   property p_no_irq_disabled;
      @(posedge clk) disable iff (!rst_n)
         (state == MDMGT_SIGNAL) && !ie |=> !mgmt_irq;
   endproperty
   a_no_irq_disabled: assert property (p_no_irq_disabled)
      else $error("interrupt raised while disabled");
   property p_preamble_ones;
      @(posedge clk) disable iff (!rst_n)
         run && (bitno < `MDMGT_PREAMBLE_BITS) |-> mdio_oe && mdio_out;
   endproperty
   a_preamble_ones: assert property (p_preamble_ones)
      else $error("preamble bit not a driven one");
   property p_read_release;
      @(posedge clk) disable iff (!rst_n)
         run && (op == `MDMGT_OP_READ) |->
         (mdio_oe == (bitno < `MDMGT_READ_RELEASE));
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("read line drive wrong for bit position");
   property p_write_driven;
      @(posedge clk) disable iff (!rst_n)
         run && (op == `MDMGT_OP_WRITE) |-> mdio_oe;
   endproperty
   a_write_driven: assert property (p_write_driven)
      else $error("write frame not driven");
   property p_mdc_high_time;
      @(posedge clk) disable iff (!rst_n)
         $rose(mdc) |-> ##24 mdc ##1 !mdc;
   endproperty
   a_mdc_high_time: assert property (p_mdc_high_time)
      else $error("management clock high time wrong");
   property p_bit_on_fall;
      @(posedge clk) disable iff (!rst_n)
         run && $past(run) && $changed(bitno) |-> $fell(mdc);
   endproperty
   a_bit_on_fall: assert property (p_bit_on_fall)
      else $error("bit advanced off the falling edge");
   property p_mdc_idle_low;
      @(posedge clk) disable iff (!rst_n)
         (state == MDMGT_IDLE) |-> ##1 !mdc;
   endproperty
   a_mdc_idle_low: assert property (p_mdc_idle_low)
      else $error("management clock running while idle");

endmodule : mdmgt_master

// ==== mdmgt_phy_model.sv ====
// Behavioural transceiver management port facing the management master
`timescale 1ns/1ns
module mdmgt_phy_model (
   input wire logic clk,
   input wire logic mdc,
   input wire logic mdio_line,
   input wire logic mdio_oe,
   output logic phy_out,
   output logic phy_oe,
   output logic [63:0] frame_bits,
   output logic [7:0] frame_count,
   output logic [7:0] clash_count
);
   logic [15:0] regs [0:31]; // Transceiver register file
   logic [63:0] shift; // Bits seen so far in this frame
   int rise_idx; // Rising edges seen in this frame, 64 when idle

   // Distinct start values so a read cannot pass by accident
   initial begin
      for (int i = 0; i < 32; i++) regs[i] = 16'h8421 ^ 16'(i);
      rise_idx = 64;
      shift = 64'h0;
      frame_bits = 64'h0;
      frame_count = 8'h0;
      clash_count = 8'h0;
      phy_oe = 1'b0;
      phy_out = 1'b1;
   end

   // A frame begins when the master takes the line
   always @(posedge mdio_oe) rise_idx = 0;

   // Sample on the rise, then change our own bit after it
   always @(posedge mdc) begin
      if (rise_idx < 64) begin
         shift[63 - rise_idx] = mdio_line;
         if (shift[29:28] == 2'b10 && rise_idx >= 47) begin
            phy_oe = 1'b1;
            if (rise_idx == 47) phy_out = 1'b0;
            else phy_out = regs[shift[22:18]][63 - rise_idx];
         end
         rise_idx++;
         if (rise_idx == 64) begin
            frame_bits = shift;
            frame_count++;
            if (shift[29:28] == 2'b01) regs[shift[22:18]] = shift[15:0];
         end
      end
   end

   // Let go after the last bit; the pull-up takes the line back
   always @(negedge mdc) if (rise_idx == 64) phy_oe <= #16 1'b0;

   // Both ends driving at once is a fault worth counting
   always @(posedge clk) if (mdio_oe && phy_oe) clash_count++;
endmodule : mdmgt_phy_model

// ==== tb_mdmgt_master.sv ====
// Self-checking bench for the management master and its control register
`timescale 1ns/1ns
module tb_mdmgt_master;
   logic clk = 1'b0; // System clock
   logic rst_n = 1'b0; // Reset, active low
   logic [7:0] reg_addr = 8'h10; // Register address
   logic reg_wr = 1'b0; // Write strobe
   logic [3:0] reg_be = 4'h0; // Byte enables
   logic [31:0] reg_wdata = 32'h0; // Write data
   logic [31:0] reg_rdata; // Read data
   logic mgmt_irq, mdc, mdio_out, mdio_oe, phy_out, phy_oe;
   logic [63:0] frame_bits; // Last frame seen by the transceiver
   logic [7:0] frame_count, clash_count;
   wire mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1); // Pull-up
   int mismatches = 0;
   int tests_run = 0;
   logic [31:0] v, cmd; // Read value and command word
   logic [4:0] idx_tab [0:1] = '{5'h07, 5'h1c}; // Read targets
   logic [15:0] dat_tab [0:1] = '{16'hb4e1, 16'h843d}; // Their contents
   int n; // Polls until ready

   always #4 clk = ~clk;

   mdmgt_master i_mdmgt_master (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_be(reg_be), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .mgmt_irq(mgmt_irq), .mdc(mdc),
      .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
   mdmgt_phy_model i_mdmgt_phy_model (.clk(clk), .mdc(mdc),
      .mdio_line(mdio_line), .mdio_oe(mdio_oe), .phy_out(phy_out),
      .phy_oe(phy_oe), .frame_bits(frame_bits), .frame_count(frame_count),
      .clash_count(clash_count));

   // Compare and count
   task check(input string what, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Report the counts and end the run
   task tally_and_finish;
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // One-cycle write strobe with lanes chosen by the enables
   task reg_write(input logic [3:0] be, input logic [31:0] d);
      @(negedge clk);
      reg_addr = 8'h10;
      reg_be = be;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : reg_write

   // Reads are address driven; data shows one cycle later
   task reg_read(input logic [7:0] a, output logic [31:0] d);
      @(negedge clk);
      reg_addr = a;
      @(negedge clk);
      @(negedge clk);
      d = reg_rdata;
   endtask : reg_read

   // Software polls the ready flag before the next command
   task wait_ready(output int polls);
      for (polls = 0; polls < 3000; polls++) begin
         reg_read(8'h10, v);
         if (v[28] === 1'b1) return;
      end
      mismatches++;
      tally_and_finish;
   endtask : wait_ready

   initial begin
      repeat (20) @(negedge clk);
      check("idle oe", mdio_oe, 1'b0);
      rst_n = 1'b1;
      reg_read(8'h10, v);
      check("reset value", v, 32'h10000000);
      reg_read(8'h14, v);
      check("unmapped", v, 32'h0);
      // Write frame from byte writes, top byte last
      cmd = {2'b11, 1'b1, 1'b0, 2'b01, 5'h13, 5'h07, 16'hb4e1};
      reg_write(4'h2, cmd);
      reg_write(4'h1, cmd);
      reg_write(4'h4, cmd);
      reg_read(8'h10, v);
      check("no start on low lanes", v[28], 1'b1);
      reg_write(4'h8, cmd);
      reg_write(4'hf, 32'h0a220000); // Refused while busy
      wait_ready(n);
      check("irq before ready", mgmt_irq, 1'b1);
      check("write frame", frame_bits, {32'hffffffff, 2'b01, 2'b01, 5'h13,
         5'h07, 2'b10, 16'hb4e1});
      check("readback", v, {2'b00, 1'b1, 1'b1, 2'b01, 5'h13, 5'h07,
         16'hb4e1});
      check("frames", frame_count, 8'h1);
      // Reads with interrupt disabled
      for (int i = 0; i < 2; i++) begin
         reg_write(4'hf, {2'b00, 1'b0, 1'b0, 2'b10, 5'h09, idx_tab[i], 16'h0});
         wait_ready(n);
         check("slow clock", n > 1065, 1'b1);
         check("irq off", mgmt_irq, 1'b0);
         check("read header", frame_bits[63:18], {32'hffffffff, 2'b01, 2'b10,
            5'h09, idx_tab[i]});
         check("read data", v, {4'b0001, 2'b10, 5'h09, idx_tab[i],
            dat_tab[i]});
      end
      // Reserved codes finish without a frame
      for (int i = 0; i < 2; i++) begin
         reg_write(4'hf, {2'b00, 1'b1, 1'b0, i ? 2'b11 : 2'b00, 26'h0});
         wait_ready(n);
         check("reserved irq", mgmt_irq, 1'b1);
         check("reserved frames", frame_count, 8'h3);
         check("mdc idle", mdc, 1'b0);
      end
      check("clash", clash_count, 8'h0);
      tally_and_finish;
   end
endmodule : tb_mdmgt_master
